// ---- ee_defines.svh ----
// Purpose: shared constants for the two-wire eeprom slave and its bus master
// Assumes: one system clock at 10 MHz on both ends
// Notes: counts derived from times stay expressions of the printed figures
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH

// ****************************************************************
// array geometry
// ****************************************************************
`define EE_BLOCKS 8
`define EE_BLOCK_BYTES 1024
`define EE_MEM_BYTES (`EE_BLOCKS * `EE_BLOCK_BYTES)
`define EE_ADDR_W 13
`define EE_PAGE_BYTES 32
`define EE_PAGE_W 5

// ****************************************************************
// select byte fields
// ****************************************************************
`define EE_SEL_TYPE_HI 7
`define EE_SEL_TYPE_LO 4
`define EE_SEL_PIN_HI 3
`define EE_SEL_PIN_LO 1
`define EE_SEL_RW 0
`define EE_BITS_PER_BYTE 4'h8

// ****************************************************************
// timing
// ****************************************************************
`define EE_CLK_KHZ 10000
`define EE_SCL_KHZ 100
`define EE_QTR_CYC (`EE_CLK_KHZ / (4 * `EE_SCL_KHZ))
`define EE_TPROG_US 5000
`define EE_PROG_CYC (`EE_TPROG_US * (`EE_CLK_KHZ / 1000))

// ****************************************************************
// buffering
// ****************************************************************
`define EE_FIFO_DEPTH 8
`define EE_FIFO_WIDTH 8

`endif

// ---- ee_pkg.sv ----
// Purpose: types shared by the eeprom slave and the bus master
// Assumes: nothing beyond the defines header
// Notes: enums carry no codes on purpose
package ee_pkg;

   // ****************************************************************
   // slave side
   // ****************************************************************
   typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK, S_PROG} ee_sst_t;
   typedef enum logic [1:0] {K_SEL, K_AHI, K_ALO, K_DATA} ee_kind_t;

   // ****************************************************************
   // master side
   // ****************************************************************
   typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_PUSH, M_STOP} ee_mst_t;

endpackage

// ---- ee_bus_if.sv ----
// Purpose: the shared two-wire bus between master end and slave end
// Assumes: both wires pulled up, every driver open drain
// Notes: the wire level is resolved here from the enables
`timescale 1ns/1ns

interface ee_bus_if;
   logic scl_out_m;
   logic scl_oe_m;
   logic sda_out_m;
   logic sda_oe_m;
   logic sda_out_d;
   logic sda_oe_d;
   logic scl;
   logic sda;

   // pull-up wins unless an enabled driver pulls low
   assign scl = scl_oe_m ? scl_out_m : 1'b1;
   assign sda = (sda_oe_m ? sda_out_m : 1'b1) & (sda_oe_d ? sda_out_d : 1'b1);

   modport dev (input scl, input sda, output sda_out_d, output sda_oe_d);
   modport mst (input scl, input sda, output scl_out_m, output scl_oe_m,
                output sda_out_m, output sda_oe_m);
endinterface // ee_bus_if

// ---- ee_slave.sv ----
// Purpose: slave end of a 64-kbit two-wire serial eeprom
// Assumes: scl well below clk_sys/4, bus pins asynchronous to clk_sys
// Notes: rst is the supply-derived power-on reset
//
// Function
// (R1) 8192 bytes as eight 1024-byte blocks
// (R2) select upper nibble must match type code
// (R3) select bits 3..1 match slot pins
// (R4) slot pins compared live, never latched
// (R5) select byte msb first, bit0 read/write
// (R6) transaction opens with start and select
// (R7) device acks received bytes in ninth bit
// (R8) master acks each read byte; ee_master acks only when cmd_ack is set
// (R9) current read returns byte at pointer
// (R10) random read: address then restart read
// (R11) sequential read continues while master acks
// (R12) byte write or page up to 32
// (R13) master ends every transfer with stop
// (R14) data line driven open drain only
// (R15) protect input high protects, open reads low
// (R16) protected: acks select, address; nacks data
// (R17) power-on reset silences every operation
// (R18) start falls, stop rises, clock high
// (R19) stop after write starts programming cycle
// (R20) programming cycle ignores the bus
// (R21) data sampled on rising clock edge
// (R22) two address bytes, high first, 13 bits
// (R23) page writes wrap inside aligned page
// (R24) read pointer increments, wraps at top
`timescale 1ns/1ns
`include "ee_defines.svh"

module ee_slave #(
   parameter logic [3:0] DEV_CODE = 4'h5, // arbitrary type code value
   parameter int PROG_CYC = `EE_PROG_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   ee_bus_if.dev bus,
   input wire logic [2:0] bus_slot_select_pins,
   input wire logic write_protect_input,
   output logic prog_busy
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic scl_m;
      logic scl_s;
      logic sda_m;
      logic sda_s;
      logic scl_p;
      logic sda_p;
      logic [2:0] pin_m;
      logic [2:0] pin_s;
      logic wp_m;
      logic wp_s;
      ee_pkg::ee_sst_t st;
      ee_pkg::ee_kind_t kind;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [`EE_ADDR_W-1:0] addr;
      logic rd;
      logic mack;
      logic sda_oe;
      logic [`EE_PAGE_BYTES-1:0] mask;
      logic [16:0] prog_cnt;
      logic busy;
   } ee_slv_t;

   ee_slv_t r_q;
   ee_slv_t r_d;

   logic [7:0] mem [0:`EE_MEM_BYTES-1]; // (R1)
   logic [7:0] pbuf [0:`EE_PAGE_BYTES-1];

   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic load_tx;
   logic pb_we;
   logic [`EE_PAGE_W-1:0] pb_idx;
   logic mem_we;
   logic [`EE_ADDR_W-1:0] mem_wa;
   logic [7:0] mem_wd;

   // select decode against live pin levels
   function automatic logic sel_match(input logic [7:0] sel, input logic [2:0] pins);
      sel_match = (sel[`EE_SEL_TYPE_HI:`EE_SEL_TYPE_LO] == DEV_CODE) && // (R2)
                  (sel[`EE_SEL_PIN_HI:`EE_SEL_PIN_LO] == pins); // (R3)
   endfunction

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      r_d = r_q;
      load_tx = 1'b0;
      pb_we = 1'b0;
      pb_idx = r_q.addr[`EE_PAGE_W-1:0];
      mem_we = 1'b0;
      mem_wa = {r_q.addr[`EE_ADDR_W-1:`EE_PAGE_W], r_q.prog_cnt[`EE_PAGE_W-1:0]};
      mem_wd = pbuf[r_q.prog_cnt[`EE_PAGE_W-1:0]];
      // pins pass two flops before any logic sees them
      r_d.scl_m = bus.scl;
      r_d.scl_s = r_q.scl_m;
      r_d.sda_m = bus.sda;
      r_d.sda_s = r_q.sda_m;
      r_d.pin_m = bus_slot_select_pins;
      r_d.pin_s = r_q.pin_m; // (R4)
      r_d.wp_m = write_protect_input;
      r_d.wp_s = r_q.wp_m; // (R15)
      r_d.scl_p = r_q.scl_s;
      r_d.sda_p = r_q.sda_s;
      rise = r_q.scl_s & ~r_q.scl_p;
      fall = ~r_q.scl_s & r_q.scl_p;
      start = r_q.scl_s & r_q.scl_p & r_q.sda_p & ~r_q.sda_s; // (R18)
      stop = r_q.scl_s & r_q.scl_p & ~r_q.sda_p & r_q.sda_s; // (R18)
      if (r_q.st == ee_pkg::S_PROG)
      begin
         // bus is not watched at all while programming
         r_d.sda_oe = 1'b0; // (R20)
         mem_we = r_q.prog_cnt < 17'(`EE_PAGE_BYTES) &&
                  r_q.mask[r_q.prog_cnt[`EE_PAGE_W-1:0]];
         r_d.prog_cnt = r_q.prog_cnt + 17'h1;
         if (r_q.prog_cnt == 17'(PROG_CYC - 1))
         begin
            r_d.st = ee_pkg::S_IDLE;
            r_d.mask = '0;
         end
      end
      else if (start)
      begin
         r_d.st = ee_pkg::S_RX; // (R6)
         r_d.kind = ee_pkg::K_SEL; // (R10)
         r_d.cnt = 4'h0;
         r_d.sda_oe = 1'b0;
      end
      else if (stop)
      begin
         r_d.sda_oe = 1'b0;
         r_d.prog_cnt = '0;
         // only a write that stored data commits; a read just goes idle
         r_d.st = (|r_q.mask) ? ee_pkg::S_PROG : ee_pkg::S_IDLE; // (R19)
      end
      else
      begin
         unique case (r_q.st)
            ee_pkg::S_IDLE:
            begin
               r_d.sda_oe = 1'b0;
            end
            ee_pkg::S_RX:
            begin
               if (rise && r_q.cnt != `EE_BITS_PER_BYTE)
               begin
                  r_d.sh = {r_q.sh[6:0], r_q.sda_s}; // (R21) (R5)
                  r_d.cnt = r_q.cnt + 4'h1;
               end
               else if (fall && r_q.cnt == `EE_BITS_PER_BYTE)
               begin
                  r_d.st = ee_pkg::S_ACK;
                  r_d.cnt = 4'h0;
                  unique case (r_q.kind)
                     ee_pkg::K_SEL:
                     begin
                        if (sel_match(r_q.sh, r_q.pin_s))
                        begin
                           r_d.sda_oe = 1'b1; // (R7)
                           r_d.rd = r_q.sh[`EE_SEL_RW]; // (R5)
                        end
                        else
                        begin
                           r_d.st = ee_pkg::S_IDLE;
                        end
                     end
                     ee_pkg::K_AHI:
                     begin
                        r_d.sda_oe = 1'b1; // (R16)
                        r_d.addr[`EE_ADDR_W-1:8] = r_q.sh[`EE_ADDR_W-9:0]; // (R22)
                     end
                     ee_pkg::K_ALO:
                     begin
                        r_d.sda_oe = 1'b1; // (R16)
                        r_d.addr[7:0] = r_q.sh; // (R22)
                     end
                     ee_pkg::K_DATA:
                     begin
                        // protected data is neither acked nor stored
                        if (!r_q.wp_s) // (R16)
                        begin
                           r_d.sda_oe = 1'b1; // (R7)
                           pb_we = 1'b1; // (R12)
                           r_d.mask[r_q.addr[`EE_PAGE_W-1:0]] = 1'b1;
                           r_d.addr[`EE_PAGE_W-1:0] =
                              r_q.addr[`EE_PAGE_W-1:0] + 5'h1; // (R23)
                        end
                     end
                  endcase
               end
            end
            ee_pkg::S_ACK:
            begin
               if (fall)
               begin
                  r_d.sda_oe = 1'b0;
                  if (r_q.kind == ee_pkg::K_SEL && r_q.rd)
                  begin
                     load_tx = 1'b1; // (R9)
                  end
                  else
                  begin
                     r_d.st = ee_pkg::S_RX;
                     r_d.cnt = 4'h0;
                     unique case (r_q.kind)
                        ee_pkg::K_SEL: r_d.kind = ee_pkg::K_AHI;
                        ee_pkg::K_AHI: r_d.kind = ee_pkg::K_ALO;
                        ee_pkg::K_ALO: r_d.kind = ee_pkg::K_DATA;
                        ee_pkg::K_DATA: r_d.kind = ee_pkg::K_DATA;
                     endcase
                  end
               end
            end
            ee_pkg::S_TX:
            begin
               if (rise)
               begin
                  r_d.cnt = r_q.cnt + 4'h1;
               end
               else if (fall)
               begin
                  if (r_q.cnt == `EE_BITS_PER_BYTE)
                  begin
                     r_d.sda_oe = 1'b0;
                     r_d.st = ee_pkg::S_MACK;
                  end
                  else
                  begin
                     r_d.sh = {r_q.sh[6:0], 1'b0};
                     r_d.sda_oe = ~r_q.sh[6]; // (R14)
                  end
               end
            end
            ee_pkg::S_MACK:
            begin
               if (rise)
               begin
                  r_d.mack = ~r_q.sda_s; // (R8)
               end
               else if (fall)
               begin
                  // no ack from the master ends the read; stop is awaited
                  if (r_q.mack)
                  begin
                     load_tx = 1'b1; // (R11)
                  end
                  else
                  begin
                     r_d.st = ee_pkg::S_IDLE;
                  end
               end
            end
            ee_pkg::S_PROG:
            begin
               r_d.st = ee_pkg::S_PROG;
            end
         endcase
      end
      if (load_tx)
      begin
         r_d.st = ee_pkg::S_TX;
         r_d.cnt = 4'h0;
         r_d.mack = 1'b0;
         r_d.sh = mem[r_q.addr];
         r_d.sda_oe = ~mem[r_q.addr][7]; // (R14) (R5)
         r_d.addr = r_q.addr + 13'h1; // (R24)
      end
      r_d.busy = (r_d.st == ee_pkg::S_PROG);
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         // wires released and state idle while power-on reset holds
         r_q <= '{scl_m: 1'b1, scl_s: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
                  scl_p: 1'b1, sda_p: 1'b1, st: ee_pkg::S_IDLE,
                  kind: ee_pkg::K_SEL, default: '0}; // (R17)
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // arrays carry no reset; contents survive power-on reset
   always_ff @(posedge clk_sys)
   begin
      if (pb_we)
      begin
         pbuf[pb_idx] <= r_q.sh;
      end
      if (mem_we)
      begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign bus.sda_out_d = 1'b0; // (R14)
   assign bus.sda_oe_d = r_q.sda_oe;
   assign prog_busy = r_q.busy;

endmodule // ee_slave

// ---- ee_master.sv ----
// Purpose: bus master end driving byte commands onto the two-wire bus
// Assumes: one master, no clock stretching by the slave
// Notes: read bytes land in a small fifo; a full fifo holds scl low
`timescale 1ns/1ns
`include "ee_defines.svh"

// ****************************************************************
// fifo
// ****************************************************************
module ee_fifo #(
   parameter int W = `EE_FIFO_WIDTH,
   parameter int D = `EE_FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic full;
      logic empty;
   } ee_fifo_st_t;
   ee_fifo_st_t f_q;
   ee_fifo_st_t f_d;
   logic [W-1:0] buf_mem [0:D-1];
   logic push;
   logic pop;

   always_comb
   begin
      f_d = f_q;
      push = in_valid & ~f_q.full;
      pop = out_ready & ~f_q.empty;
      if (push)
      begin
         f_d.wp = f_q.wp + AW'(1);
      end
      if (pop)
      begin
         f_d.rp = f_q.rp + AW'(1);
      end
      f_d.cnt = f_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      f_d.full = (f_d.cnt == (AW+1)'(D));
      f_d.empty = (f_d.cnt == '0);
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         f_q <= '{empty: 1'b1, default: '0};
      end
      else
      begin
         f_q <= f_d;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (push)
      begin
         buf_mem[f_q.wp] <= in_data;
      end
   end

   assign in_ready = ~f_q.full;
   assign out_valid = ~f_q.empty;
   assign out_data = buf_mem[f_q.rp];
endmodule // ee_fifo

// ****************************************************************
// master
// ****************************************************************
module ee_master (
   input wire logic clk_sys,
   input wire logic rst,
   ee_bus_if.mst bus,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_start,
   input wire logic cmd_byte,
   input wire logic cmd_read,
   input wire logic cmd_ack,
   input wire logic cmd_stop,
   input wire logic [7:0] cmd_data,
   output logic nack_seen,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [7:0] rd_data
);
   localparam int QTR = `EE_QTR_CYC;

   typedef struct packed {
      logic sda_m;
      logic sda_s;
      ee_pkg::ee_mst_t st;
      logic [1:0] q;
      logic [4:0] tick;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic rd;
      logic ack;
      logic stop;
      logic scl_oe;
      logic sda_oe;
      logic nack;
      logic rdy;
   } ee_mst_st_t;
   ee_mst_st_t m_q;
   ee_mst_st_t m_d;
   logic qend;
   logic fifo_in_ready;

   always_comb
   begin
      m_d = m_q;
      m_d.sda_m = bus.sda;
      m_d.sda_s = m_q.sda_m;
      qend = (m_q.tick == 5'(QTR - 1));
      m_d.tick = qend ? 5'h0 : m_q.tick + 5'h1;
      if (qend)
      begin
         m_d.q = m_q.q + 2'h1;
      end
      unique case (m_q.st)
         ee_pkg::M_IDLE:
         begin
            m_d.tick = 5'h0;
            m_d.q = 2'h0;
            if (cmd_valid && m_q.rdy)
            begin
               m_d.rdy = 1'b0;
               m_d.sh = cmd_data;
               m_d.rd = cmd_read;
               m_d.ack = cmd_ack;
               m_d.stop = cmd_stop;
               m_d.bitn = cmd_byte ? 4'h0 : `EE_BITS_PER_BYTE + 4'h1;
               m_d.scl_oe = 1'b1;
               if (cmd_start)
               begin
                  m_d.st = ee_pkg::M_START; // (R6)
                  m_d.sda_oe = 1'b0;
               end
               else if (cmd_byte)
               begin
                  m_d.st = ee_pkg::M_BIT;
                  m_d.sda_oe = ~cmd_read & ~cmd_data[7]; // (R5)
               end
               else
               begin
                  m_d.st = ee_pkg::M_STOP;
                  m_d.sda_oe = 1'b1;
               end
            end
         end
         ee_pkg::M_START:
         begin
            if (qend)
            begin
               unique case (m_q.q)
                  2'h0: m_d.scl_oe = 1'b0;
                  2'h1: m_d.sda_oe = 1'b1; // (R18)
                  2'h2: m_d.scl_oe = 1'b1;
                  2'h3:
                  begin
                     if (m_q.bitn == 4'h0)
                     begin
                        m_d.st = ee_pkg::M_BIT;
                        m_d.sda_oe = ~m_q.rd & ~m_q.sh[7];
                     end
                     else
                     begin
                        m_d.st = m_q.stop ? ee_pkg::M_STOP : ee_pkg::M_IDLE;
                        m_d.rdy = ~m_q.stop;
                     end
                  end
               endcase
            end
         end
         ee_pkg::M_BIT:
         begin
            if (qend)
            begin
               unique case (m_q.q)
                  2'h0: m_d.scl_oe = 1'b0;
                  2'h1:
                  begin
                     if (m_q.bitn == `EE_BITS_PER_BYTE)
                     begin
                        m_d.nack = m_q.rd ? m_q.nack : m_q.sda_s;
                     end
                     else if (m_q.rd)
                     begin
                        m_d.sh = {m_q.sh[6:0], m_q.sda_s};
                     end
                  end
                  2'h2: m_d.scl_oe = 1'b1;
                  2'h3:
                  begin
                     m_d.bitn = m_q.bitn + 4'h1;
                     if (m_q.bitn == `EE_BITS_PER_BYTE)
                     begin
                        m_d.sda_oe = 1'b0;
                        m_d.st = m_q.rd ? ee_pkg::M_PUSH :
                                 (m_q.stop ? ee_pkg::M_STOP : ee_pkg::M_IDLE);
                        m_d.rdy = ~m_q.rd & ~m_q.stop;
                        m_d.sda_oe = ~m_q.rd & m_q.stop;
                     end
                     else if (m_q.bitn == 4'h7)
                     begin
                        m_d.sda_oe = m_q.rd & m_q.ack; // (R8)
                     end
                     else
                     begin
                        m_d.sh = m_q.rd ? m_q.sh : {m_q.sh[6:0], 1'b0};
                        m_d.sda_oe = ~m_q.rd & ~m_q.sh[6];
                     end
                  end
               endcase
            end
         end
         ee_pkg::M_PUSH:
         begin
            // scl stays low until the fifo takes the byte
            m_d.tick = 5'h0;
            m_d.q = 2'h0;
            if (fifo_in_ready)
            begin
               m_d.st = m_q.stop ? ee_pkg::M_STOP : ee_pkg::M_IDLE;
               m_d.rdy = ~m_q.stop;
               m_d.sda_oe = m_q.stop;
            end
         end
         ee_pkg::M_STOP:
         begin
            if (qend)
            begin
               unique case (m_q.q)
                  2'h0: m_d.scl_oe = 1'b0;
                  2'h1: m_d.sda_oe = 1'b0; // (R13) (R18)
                  2'h2: m_d.sda_oe = 1'b0;
                  2'h3:
                  begin
                     m_d.st = ee_pkg::M_IDLE;
                     m_d.rdy = 1'b1;
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         m_q <= '{sda_m: 1'b1, sda_s: 1'b1, st: ee_pkg::M_IDLE, rdy: 1'b1,
                  default: '0};
      end
      else
      begin
         m_q <= m_d;
      end
   end

   ee_fifo #(.W(`EE_FIFO_WIDTH), .D(`EE_FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_valid(m_q.st == ee_pkg::M_PUSH),
      .in_ready(fifo_in_ready),
      .in_data(m_q.sh),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );

   assign bus.scl_out_m = 1'b0;
   assign bus.scl_oe_m = m_q.scl_oe;
   assign bus.sda_out_m = 1'b0;
   assign bus.sda_oe_m = m_q.sda_oe;
   assign cmd_ready = m_q.rdy;
   assign nack_seen = m_q.nack;
endmodule // ee_master

// ---- ee_monitor.sv ----
// Purpose: bus checks beside the eeprom master and slave pair
// Assumes: one clock, rst asynchronous and active high
// Notes: sees the interface wires and prog_busy only
`timescale 1ns/1ns

module ee_monitor (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic scl_out_m,
   input wire logic scl_oe_m,
   input wire logic sda_out_d,
   input wire logic sda_oe_d,
   input wire logic scl,
   input wire logic sda,
   input wire logic prog_busy
);
   // ********
   // checks
   // ********
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_sda_open_drain: assert property (sda_oe_d |-> !sda_out_d)
      else $error("slave drives sda high");
   a_scl_open_drain: assert property (scl_oe_m |-> !scl_out_m)
      else $error("master drives scl high");
   a_no_slave_cond: assert property ($changed(sda_oe_d) |-> !scl)
      else $error("slave moves sda while scl high");
   a_busy_quiet: assert property (prog_busy |-> !sda_oe_d)
      else $error("slave drives sda while programming");
   a_prog_on_idle: assert property ($rose(prog_busy) |-> scl && sda)
      else $error("programming began on a busy bus");
   a_prog_span: assert property ($rose(prog_busy) |-> prog_busy[*8] ##[1:600] !prog_busy)
      else $error("programming cycle length wrong");
   a_reset_quiet: assert property ($fell(rst) |-> !sda_oe_d && !prog_busy)
      else $error("slave active at reset release");
   a_bit_hold: assert property ($rose(sda_oe_d) |-> sda_oe_d[*8])
      else $error("slave drive too short");
endmodule // ee_monitor

// ---- serial_eeprom_slave_interface_test.sv ----
// Purpose: self-checking bench for the eeprom master and slave pair
// Assumes: device code 4'h5, slot pins 3'h6, so select bytes 8'h5c and 8'h5d
// Notes: programming cycle shortened to 400 clocks; read fifo never filled
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin $display("[FAIL] %s exp %h got %h", n, e, g); n_errors++; end end

module serial_eeprom_slave_interface_test;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [2:0] bus_slot_select_pins = 3'h6;
   logic write_protect_input = 1'b0;
   logic cmd_valid, cmd_start, cmd_byte, cmd_read, cmd_ack, cmd_stop, rd_ready;
   logic [7:0] cmd_data;
   logic cmd_ready, nack_seen, rd_valid, prog_busy;
   logic [7:0] rd_data;
   int n_errors = 0;
   int check_count = 0;

   ee_bus_if bus ();
   ee_slave #(.PROG_CYC(400)) i_ee_slave (.clk_sys, .rst, .bus(bus), .bus_slot_select_pins,
      .write_protect_input, .prog_busy);
   ee_master i_ee_master (.clk_sys, .rst, .bus(bus), .cmd_valid, .cmd_ready, .cmd_start,
      .cmd_byte, .cmd_read, .cmd_ack, .cmd_stop, .cmd_data, .nack_seen, .rd_valid,
      .rd_ready, .rd_data);
   ee_monitor i_ee_monitor (.clk_sys, .rst, .scl_out_m(bus.scl_out_m), .scl_oe_m(bus.scl_oe_m),
      .sda_out_d(bus.sda_out_d), .sda_oe_d(bus.sda_oe_d), .scl(bus.scl), .sda(bus.sda),
      .prog_busy);

   always #50 clk_sys = ~clk_sys;

   // ********
   // helpers
   // ********
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic lim(input int k);
      if (k >= 5000)
      begin
         n_errors++;
         stop_test();
      end
   endtask

   // flags are start, byte, read, ack, stop
   task automatic cmd(input logic [4:0] f, input logic [7:0] d);
      int k;
      @(posedge clk_sys);
      {cmd_start, cmd_byte, cmd_read, cmd_ack, cmd_stop, cmd_data} <= {f, d};
      cmd_valid <= 1'b1;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      @(negedge clk_sys);
      for (k = 0; k < 5000 && cmd_ready !== 1'b1; k++) @(negedge clk_sys);
      lim(k);
   endtask

   task automatic rd(input logic [4:0] f, input logic [7:0] e);
      int k;
      cmd(f, 8'h00);
      for (k = 0; k < 5000 && rd_valid !== 1'b1; k++) @(negedge clk_sys);
      lim(k);
      `CHK("rd_data", e, rd_data)
      @(posedge clk_sys) rd_ready <= 1'b1;
      @(posedge clk_sys) rd_ready <= 1'b0;
   endtask

   // select for write, then both address bytes, no stop
   task automatic adr(input logic [15:0] a);
      cmd(5'b11000, 8'h5c);
      cmd(5'b01000, a[15:8]);
      cmd(5'b01000, a[7:0]);
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d0, d1, d2, input int n);
      int k;
      adr(a);
      cmd({4'b0100, n == 1}, d0);
      if (n > 1) cmd({4'b0100, n == 2}, d1);
      if (n > 2) cmd(5'b01001, d2);
      `CHK("prog_busy", 1'b1, prog_busy)
      for (k = 0; k < 5000 && prog_busy !== 1'b0; k++) @(negedge clk_sys);
      lim(k);
   endtask

   // ********
   // scenarios
   // ********
   task automatic t_wrap;
      wr(16'hffff, 8'ha5, 8'h00, 8'h00, 1);
      wr(16'h0000, 8'h3c, 8'h00, 8'h00, 1);
      adr(16'h1fff);
      cmd(5'b11000, 8'h5d);
      rd(5'b01101, 8'ha5);
      cmd(5'b11000, 8'h5d);
      rd(5'b01101, 8'h3c);
      $display("t_wrap done");
   endtask

   task automatic t_page;
      wr(16'h003e, 8'h11, 8'h22, 8'h33, 3);
      adr(16'h003e);
      cmd(5'b11000, 8'h5d);
      rd(5'b01110, 8'h11);
      rd(5'b01101, 8'h22);
      adr(16'h0020);
      cmd(5'b11000, 8'h5d);
      rd(5'b01101, 8'h33);
      $display("t_page done");
   endtask

   task automatic t_sel;
      @(posedge clk_sys) bus_slot_select_pins <= 3'h3;
      cmd(5'b11001, 8'h5c);
      `CHK("nack_seen", 1'b1, nack_seen)
      @(posedge clk_sys) bus_slot_select_pins <= 3'h6;
      cmd(5'b11001, 8'h5c);
      `CHK("nack_seen", 1'b0, nack_seen)
      cmd(5'b11001, 8'h9c);
      `CHK("nack_seen", 1'b1, nack_seen)
      $display("t_sel done");
   endtask

   task automatic t_prot;
      @(posedge clk_sys) write_protect_input <= 1'b1;
      adr(16'h1fff);
      `CHK("nack_seen", 1'b0, nack_seen)
      cmd(5'b01001, 8'hee);
      `CHK("nack_seen", 1'b1, nack_seen)
      `CHK("prog_busy", 1'b0, prog_busy)
      @(posedge clk_sys) write_protect_input <= 1'b0;
      adr(16'h1fff);
      cmd(5'b11000, 8'h5d);
      rd(5'b01101, 8'ha5);
      $display("t_prot done");
   endtask

   initial
   begin
      {cmd_valid, cmd_start, cmd_byte, cmd_read, cmd_ack, cmd_stop, rd_ready} <= 7'h00;
      cmd_data <= 8'h00;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      t_wrap();
      t_page();
      t_sel();
      t_prot();
      stop_test();
   end
endmodule // serial_eeprom_slave_interface_test
